/* File: src/pmd_fetch_decode.sv */
`timescale 1ns/100ps
module pmd_fetch_decode
	import pmd_pkg::*;
#(
	parameter int STROBE_CYC = EXT_STROBE_CYC
)
(
	input  logic        ref_clk_i,
	input  logic        rst_n_i,
	input  logic [7:0]  reg_addr_i,
	input  logic [7:0]  reg_wdata_i,
	input  logic        reg_wr_i,
	input  logic        reg_rd_i,
	output logic [7:0]  reg_rdata_o,
	input  logic        fetch_req_i,
	input  logic [15:0] fetch_addr_i,
	output logic [7:0]  fetch_data_o,
	output logic        fetch_done_o,
	output logic        fetch_ext_o,
	output logic        fetch_busy_o,
	input  logic        force_external_fetch_n_i,
	output logic        rom_rd_o,
	output logic [13:0] rom_addr_o,
	input  logic [7:0]  rom_rdata_i,
	input  logic [7:0]  low_addr_data_port_i,
	output logic [7:0]  low_addr_data_port_o,
	output logic        low_addr_data_port_oe_n_o,
	output logic [7:0]  high_addr_port_o,
	output logic        addr_latch_en_o,
	output logic        program_store_strobe_n_o
);

	// ************************************************
	// elaboration checks
	// ************************************************
	generate
		if (STROBE_CYC < 1 || STROBE_CYC > 15)
		begin : g_bad_strobe
			$error("STROBE_CYC must lie in 1..15");
		end
	endgenerate

	localparam logic [3:0] STRB_LAST = 4'(STROBE_CYC - 1);

	// ************************************************
	// state
	// ************************************************
	pmd_fetch_state_e state_q;
	logic [2:0]       limit_q;
	logic             ta_armed_q;
	logic [1:0]       ta_open_q;
	logic [3:0]       strb_cnt_q;
	logic [15:0]      addr_q;
	logic             take;
	logic             go_int;
	logic             wr_limit;
	logic             wr_ta;
	logic             legal_code;

	assign take       = fetch_req_i && (state_q == FS_IDLE);
	// pin override wins over any limit; only rom sits behind the internal path
	assign go_int     = force_external_fetch_n_i
		&& pmd_is_internal(fetch_addr_i, limit_q);
	assign wr_limit   = reg_wr_i && (reg_addr_i == ADDR_ROM_SIZE_LIMIT);
	assign wr_ta      = reg_wr_i && (reg_addr_i == ADDR_TIMED_ACCESS);
	assign legal_code = reg_wdata_i[LIMIT_LSB +: LIMIT_W] <= LIM_16K;

	// ************************************************
	// timed access window
	// ************************************************
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			ta_armed_q <= 1'b0;
			ta_open_q  <= 2'h0;
		end
		else if (wr_ta)
		begin
			ta_armed_q <= (reg_wdata_i == TA_KEY_FIRST);
			if (ta_armed_q && reg_wdata_i == TA_KEY_SECOND)
				ta_open_q <= TA_WINDOW_CYC;
			else
				ta_open_q <= 2'h0;
		end
		else
		begin
			ta_armed_q <= 1'b0;
			// a protected write spends the window
			if (wr_limit)
				ta_open_q <= 2'h0;
			else if (ta_open_q != 2'h0)
				ta_open_q <= ta_open_q - 2'h1;
		end
	end

	// ************************************************
	// rom size limit
	// ************************************************
	// reserved codes are dropped so the decode never sees them
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
			limit_q <= LIMIT_RESET;
		else if (wr_limit && ta_open_q != 2'h0 && legal_code)
			limit_q <= reg_wdata_i[LIMIT_LSB +: LIMIT_W];
	end

	// ************************************************
	// register reads
	// ************************************************
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
			reg_rdata_o <= 8'h00;
		else if (reg_rd_i)
		begin
			reg_rdata_o <= 8'h00;
			unique case (reg_addr_i)
				ADDR_ROM_SIZE_LIMIT: reg_rdata_o[LIMIT_LSB +: LIMIT_W] <= limit_q;
				ADDR_FETCH_STATUS:
				begin
					reg_rdata_o[STAT_BUSY_BIT] <= fetch_busy_o;
					reg_rdata_o[STAT_EXT_BIT]  <= fetch_ext_o;
					reg_rdata_o[STAT_TA_BIT]   <= (ta_open_q != 2'h0);
				end
				default: reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// ************************************************
	// fetch sequencer
	// ************************************************
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			state_q    <= FS_IDLE;
			strb_cnt_q <= 4'h0;
			addr_q     <= 16'h0000;
		end
		else
		begin
			unique case (state_q)
				FS_IDLE:
					if (take)
					begin
						addr_q  <= fetch_addr_i;
						state_q <= go_int ? FS_INT : FS_ALE;
					end
				FS_INT:
					state_q <= FS_IDLE;
				FS_ALE:
				begin
					strb_cnt_q <= 4'h0;
					state_q    <= FS_STRB;
				end
				FS_STRB:
					if (strb_cnt_q == STRB_LAST)
						state_q <= FS_IDLE;
					else
						strb_cnt_q <= strb_cnt_q + 4'h1;
			endcase
		end
	end

	// ************************************************
	// internal rom port
	// ************************************************
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			rom_rd_o   <= 1'b0;
			rom_addr_o <= 14'h0000;
		end
		else
		begin
			rom_rd_o <= take && go_int;
			if (take && go_int)
				rom_addr_o <= fetch_addr_i[13:0];
		end
	end

	// ************************************************
	// external bus pins
	// ************************************************
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			low_addr_data_port_o      <= 8'h00;
			low_addr_data_port_oe_n_o <= 1'b1;
			high_addr_port_o          <= 8'h00;
			addr_latch_en_o           <= 1'b0;
			program_store_strobe_n_o  <= 1'b1;
		end
		else
		begin
			if (take && !go_int)
			begin
				low_addr_data_port_o      <= fetch_addr_i[7:0];
				low_addr_data_port_oe_n_o <= 1'b0;
				high_addr_port_o          <= fetch_addr_i[15:8];
				addr_latch_en_o           <= 1'b1;
			end
			else if (state_q == FS_ALE)
			begin
				// release the low port so the memory can drive data
				low_addr_data_port_oe_n_o <= 1'b1;
				addr_latch_en_o           <= 1'b0;
				program_store_strobe_n_o  <= 1'b0;
			end
			else if (state_q == FS_STRB && strb_cnt_q == STRB_LAST)
				program_store_strobe_n_o <= 1'b1;
		end
	end

	// ************************************************
	// fetch answer
	// ************************************************
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			fetch_data_o <= 8'h00;
			fetch_done_o <= 1'b0;
			fetch_ext_o  <= 1'b0;
			fetch_busy_o <= 1'b0;
		end
		else
		begin
			fetch_done_o <= 1'b0;
			if (take)
			begin
				fetch_busy_o <= 1'b1;
				fetch_ext_o  <= !go_int;
			end
			else if (state_q == FS_INT)
			begin
				fetch_data_o <= rom_rdata_i;
				fetch_done_o <= 1'b1;
				fetch_busy_o <= 1'b0;
			end
			else if (state_q == FS_STRB && strb_cnt_q == STRB_LAST)
			begin
				// data sampled on the last strobe cycle, before it rises
				fetch_data_o <= low_addr_data_port_i;
				fetch_done_o <= 1'b1;
				fetch_busy_o <= 1'b0;
			end
		end
	end

	// ************************************************
	// assertions
	// ************************************************
	property p_int_fetch;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		take && go_int |-> ##1 rom_rd_o && !addr_latch_en_o ##1 fetch_done_o && !fetch_ext_o;
	endproperty
	a_int_fetch: assert property (p_int_fetch) else $error("internal fetch path wrong");

	property p_above_limit;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		take && force_external_fetch_n_i && !pmd_is_internal(fetch_addr_i, limit_q)
		|-> ##1 addr_latch_en_o && !rom_rd_o ##1 !program_store_strobe_n_o;
	endproperty
	a_above_limit: assert property (p_above_limit) else $error("high fetch not external");

	property p_map_4k;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		take && force_external_fetch_n_i && limit_q == LIM_4K
		|-> ##1 (rom_rd_o == (addr_q <= TOP_4K));
	endproperty
	a_map_4k: assert property (p_map_4k) else $error("4k limit decode wrong");

	property p_reset_limit;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		$rose(rst_n_i) |-> limit_q == LIMIT_RESET;
	endproperty
	a_reset_limit: assert property (p_reset_limit) else $error("limit not full after reset");

	property p_unprotected;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		wr_limit && ta_open_q == 2'h0 |=> $stable(limit_q);
	endproperty
	a_unprotected: assert property (p_unprotected) else $error("unprotected write took effect");

	property p_immediate;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		wr_limit && ta_open_q != 2'h0 && legal_code
		|=> limit_q == $past(reg_wdata_i[LIMIT_LSB +: LIMIT_W]);
	endproperty
	a_immediate: assert property (p_immediate) else $error("limit write not applied");

	property p_addr_pins;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		addr_latch_en_o |-> !low_addr_data_port_oe_n_o
		&& {high_addr_port_o, low_addr_data_port_o} == addr_q;
	endproperty
	a_addr_pins: assert property (p_addr_pins) else $error("address pins wrong");

	property p_force_ext;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		take && !force_external_fetch_n_i |-> ##1 addr_latch_en_o && fetch_ext_o && !rom_rd_o;
	endproperty
	a_force_ext: assert property (p_force_ext) else $error("override pin ignored");

	property p_strobe;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		!program_store_strobe_n_o |-> low_addr_data_port_oe_n_o && fetch_ext_o
		&& !addr_latch_en_o;
	endproperty
	a_strobe: assert property (p_strobe) else $error("strobe low with port driven");

	property p_strobe_end;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		$rose(program_store_strobe_n_o) |-> fetch_done_o && fetch_ext_o;
	endproperty
	a_strobe_end: assert property (p_strobe_end) else $error("strobe end without answer");

	property p_zero_code;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		take && limit_q == LIM_NONE |-> ##1 !rom_rd_o && addr_latch_en_o;
	endproperty
	a_zero_code: assert property (p_zero_code) else $error("code zero fetched inside");

	c_int: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) take && go_int);
	c_ext: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		$rose(program_store_strobe_n_o));
	c_ta: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		wr_limit && ta_open_q != 2'h0);
	c_force: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		take && !force_external_fetch_n_i);

endmodule

/* File: src/pmd_pkg.sv */
package pmd_pkg;

	// ************************************************
	// register map
	// ************************************************
	localparam logic [7:0]  ADDR_ROM_SIZE_LIMIT = 8'hC2;
	localparam logic [7:0]  ADDR_FETCH_STATUS   = 8'hC3;
	localparam logic [7:0]  ADDR_TIMED_ACCESS   = 8'hC7;

	localparam logic [2:0]  LIMIT_RESET         = 3'h5;
	localparam int          LIMIT_LSB           = 0;
	localparam int          LIMIT_W             = 3;
	localparam int          STAT_BUSY_BIT       = 0;
	localparam int          STAT_EXT_BIT        = 1;
	localparam int          STAT_TA_BIT         = 2;

	// ************************************************
	// timed access sequence
	// ************************************************
	localparam logic [7:0]  TA_KEY_FIRST        = 8'hAA;
	localparam logic [7:0]  TA_KEY_SECOND       = 8'h55;
	localparam logic [1:0]  TA_WINDOW_CYC       = 2'h3;

	// ************************************************
	// limit codes and highest internal address
	// ************************************************
	localparam logic [2:0]  LIM_NONE            = 3'h0;
	localparam logic [2:0]  LIM_1K              = 3'h1;
	localparam logic [2:0]  LIM_2K              = 3'h2;
	localparam logic [2:0]  LIM_4K              = 3'h3;
	localparam logic [2:0]  LIM_8K              = 3'h4;
	localparam logic [2:0]  LIM_16K             = 3'h5;
	localparam logic [15:0] TOP_1K              = 16'h03FF;
	localparam logic [15:0] TOP_2K              = 16'h07FF;
	localparam logic [15:0] TOP_4K              = 16'h0FFF;
	localparam logic [15:0] TOP_8K              = 16'h1FFF;
	localparam logic [15:0] TOP_16K             = 16'h3FFF;

	// ************************************************
	// external fetch timing
	// ************************************************
	localparam int          EXT_STROBE_CYC      = 2;

	typedef enum logic [1:0]
	{
		FS_IDLE = 2'b00,
		FS_INT  = 2'b01,
		FS_ALE  = 2'b10,
		FS_STRB = 2'b11
	} pmd_fetch_state_e;

	function automatic logic pmd_is_internal(input logic [15:0] addr, input logic [2:0] code);
		logic [15:0] top;
		logic        any;
		top = TOP_16K;
		any = 1'b1;
		unique case (code)
			LIM_1K:  top = TOP_1K;
			LIM_2K:  top = TOP_2K;
			LIM_4K:  top = TOP_4K;
			LIM_8K:  top = TOP_8K;
			LIM_16K: top = TOP_16K;
			default: any = 1'b0;
		endcase
		return any && (addr <= top);
	endfunction

endpackage

/* File: test/pmd_ext_prog_mem.sv */
`timescale 1ns/100ps
// ****************************************
// external program memory on the expansion bus
// ****************************************
module pmd_ext_prog_mem
(
	input  logic       ref_clk_i,
	input  logic [7:0] low_addr_i,
	input  logic [7:0] high_addr_i,
	input  logic       addr_latch_en_i,
	input  logic       port_oe_n_i,
	input  logic       strobe_n_i,
	output logic [7:0] data_o
);
	logic [7:0] low_q;
	logic [7:0] last_q;
	logic [7:0] word;

	assign word = low_q ^ high_addr_i ^ 8'h5A;

	always_ff @(posedge ref_clk_i)
	begin
		// only a low byte that the device really drives is latched
		if (addr_latch_en_i && !port_oe_n_i)
			low_q <= low_addr_i;
		if (!strobe_n_i)
			last_q <= word;
	end

	// a released bus shows the inverse, so a mistimed sample cannot match by luck
	assign data_o = !strobe_n_i ? word : ~last_q;
endmodule

/* File: test/test_program_memory_decode.sv */
`timescale 1ns/100ps
module test_program_memory_decode;
	import pmd_pkg::*;
	// ****************************************
	// bench signals
	// ****************************************
	localparam int STROBE = 3;
	localparam logic [15:0] TOPS [6] = '{16'h0000, TOP_1K, TOP_2K, TOP_4K, TOP_8K, TOP_16K};
	logic        ref_clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_rdata;
	logic        fetch_req = 1'b0;
	logic [15:0] fetch_addr = 16'h0000;
	logic [7:0]  fetch_data;
	logic        fetch_done;
	logic        fetch_ext;
	logic        fetch_busy;
	logic        force_n = 1'b1;
	logic        rom_rd;
	logic [13:0] rom_addr;
	logic [7:0]  rom_rdata;
	logic [7:0]  port_in;
	logic [7:0]  port_out;
	logic        port_oe_n;
	logic [7:0]  high_addr;
	logic        ale;
	logic        strobe_n;
	int          miscompares = 0;
	int          checks = 0;
	int          cycles = 0;

	always #10 ref_clk_i = ~ref_clk_i;

	// on-chip rom answers straight from the held address
	assign rom_rdata = rom_addr[7:0] ^ {2'b00, rom_addr[13:8]} ^ 8'hC3;

	pmd_fetch_decode #(.STROBE_CYC(STROBE)) u_pmd_fetch_decode
	(
		.ref_clk_i                (ref_clk_i),
		.rst_n_i                  (rst_n_i),
		.reg_addr_i               (reg_addr),
		.reg_wdata_i              (reg_wdata),
		.reg_wr_i                 (reg_wr),
		.reg_rd_i                 (reg_rd),
		.reg_rdata_o              (reg_rdata),
		.fetch_req_i              (fetch_req),
		.fetch_addr_i             (fetch_addr),
		.fetch_data_o             (fetch_data),
		.fetch_done_o             (fetch_done),
		.fetch_ext_o              (fetch_ext),
		.fetch_busy_o             (fetch_busy),
		.force_external_fetch_n_i (force_n),
		.rom_rd_o                 (rom_rd),
		.rom_addr_o               (rom_addr),
		.rom_rdata_i              (rom_rdata),
		.low_addr_data_port_i     (port_in),
		.low_addr_data_port_o     (port_out),
		.low_addr_data_port_oe_n_o(port_oe_n),
		.high_addr_port_o         (high_addr),
		.addr_latch_en_o          (ale),
		.program_store_strobe_n_o (strobe_n)
	);

	pmd_ext_prog_mem u_pmd_ext_prog_mem
	(
		.ref_clk_i      (ref_clk_i),
		.low_addr_i     (port_out),
		.high_addr_i    (high_addr),
		.addr_latch_en_i(ale),
		.port_oe_n_i    (port_oe_n),
		.strobe_n_i     (strobe_n),
		.data_o         (port_in)
	);

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
	endtask

	task automatic idle;
		@(posedge ref_clk_i);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk_i);
		reg_addr <= a;
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge ref_clk_i);
		reg_rd <= 1'b0;
		#1 check(reg_rdata, e);
	endtask

	task automatic ta_limit(input logic [2:0] c);
		wr(ADDR_TIMED_ACCESS, TA_KEY_FIRST);
		wr(ADDR_TIMED_ACCESS, TA_KEY_SECOND);
		wr(ADDR_ROM_SIZE_LIMIT, {5'h00, c});
		idle();
	endtask

	task automatic fetch(input logic [15:0] a, input logic ext);
		int         n;
		int         strb;
		int         roms;
		int         busy;
		int         oes;
		logic [7:0] e;
		n = 0;
		strb = 0;
		roms = 0;
		busy = 0;
		oes = 0;
		e = ext ? (a[7:0] ^ a[15:8] ^ 8'h5A) : (a[7:0] ^ {2'b00, a[13:8]} ^ 8'hC3);
		@(posedge ref_clk_i);
		fetch_req <= 1'b1;
		fetch_addr <= a;
		@(posedge ref_clk_i);
		fetch_req <= 1'b0;
		#1;
		while (fetch_done !== 1'b1 && n < 40)
		begin
			strb += int'(strobe_n === 1'b0);
			roms += int'(rom_rd === 1'b1);
			busy += int'(fetch_busy === 1'b1);
			oes += int'(port_oe_n === 1'b0);
			@(posedge ref_clk_i);
			#1;
			n++;
		end
		check(16'(n), ext ? 16'(1 + STROBE) : 16'h0001);
		check(16'(busy), ext ? 16'(1 + STROBE) : 16'h0001);
		check(fetch_busy, 1'b0);
		check(16'(oes), ext ? 16'h0001 : 16'h0000);
		check(fetch_ext, ext);
		check(fetch_data, e);
		check(16'(strb), ext ? 16'(STROBE) : 16'h0000);
		check(16'(roms), ext ? 16'h0000 : 16'h0001);
		if (ext)
			check(high_addr, a[15:8]);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		rd(ADDR_ROM_SIZE_LIMIT, 8'h05);
		fetch(16'h0000, 1'b0);
		fetch(TOP_16K, 1'b0);
		fetch(16'h4000, 1'b1);
		$display("test reset done");
	endtask

	task automatic t_codes;
		// limit changes are issued between fetches, never mid-fetch
		for (int c = 5; c >= 0; c--)
		begin
			ta_limit(3'(c));
			rd(ADDR_ROM_SIZE_LIMIT, 8'(c));
			if (c == 0)
			begin
				fetch(16'h0000, 1'b1);
				fetch(16'hFFFF, 1'b1);
			end
			else
			begin
				fetch(TOPS[c], 1'b0);
				fetch(TOPS[c] + 16'h0001, 1'b1);
			end
		end
		ta_limit(3'h6);
		rd(ADDR_ROM_SIZE_LIMIT, 8'h00);
		ta_limit(3'h7);
		rd(ADDR_ROM_SIZE_LIMIT, 8'h00);
		ta_limit(LIM_16K);
		$display("test codes done");
	endtask

	task automatic t_protect;
		wr(ADDR_ROM_SIZE_LIMIT, 8'h01);
		idle();
		rd(ADDR_ROM_SIZE_LIMIT, 8'h05);
		wr(ADDR_TIMED_ACCESS, TA_KEY_FIRST);
		wr(ADDR_TIMED_ACCESS, TA_KEY_SECOND);
		repeat (2) idle();
		wr(ADDR_ROM_SIZE_LIMIT, 8'h02);
		idle();
		rd(ADDR_ROM_SIZE_LIMIT, 8'h02);
		wr(ADDR_TIMED_ACCESS, TA_KEY_FIRST);
		wr(ADDR_TIMED_ACCESS, TA_KEY_SECOND);
		// the status read spends two of the three idle cycles
		rd(ADDR_FETCH_STATUS, 8'h06);
		idle();
		wr(ADDR_ROM_SIZE_LIMIT, 8'h04);
		idle();
		rd(ADDR_ROM_SIZE_LIMIT, 8'h02);
		wr(ADDR_TIMED_ACCESS, TA_KEY_FIRST);
		idle();
		wr(ADDR_TIMED_ACCESS, TA_KEY_SECOND);
		wr(ADDR_ROM_SIZE_LIMIT, 8'h03);
		idle();
		rd(ADDR_ROM_SIZE_LIMIT, 8'h02);
		fetch(TOP_2K + 16'h0001, 1'b1);
		rd(8'h10, 8'h00);
		ta_limit(LIM_16K);
		$display("test protect done");
	endtask

	task automatic t_force;
		@(posedge ref_clk_i);
		force_n <= 1'b0;
		fetch(16'h0000, 1'b1);
		fetch(TOP_16K, 1'b1);
		rd(ADDR_FETCH_STATUS, 8'h02);
		@(posedge ref_clk_i);
		force_n <= 1'b1;
		fetch(16'h0000, 1'b0);
		rd(ADDR_FETCH_STATUS, 8'h00);
		$display("test force done");
	endtask

	task automatic t_rereset;
		ta_limit(LIM_1K);
		rd(ADDR_ROM_SIZE_LIMIT, 8'h01);
		@(posedge ref_clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		#1 check(strobe_n, 1'b1);
		check(port_oe_n, 1'b1);
		check(ale, 1'b0);
		rd(ADDR_ROM_SIZE_LIMIT, 8'h05);
		fetch(TOP_16K, 1'b0);
		$display("test rereset done");
	endtask

	// ****************************************
	// run control
	// ****************************************
	task automatic complete_run;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	always @(posedge ref_clk_i)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			miscompares++;
			complete_run();
		end
	end

	initial
	begin
		repeat (6) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_codes();
		t_protect();
		t_force();
		t_rereset();
		complete_run();
	end
endmodule
